//--- dv/pin_board.sv
// board model of the six pins: design drivers, external drivers and pull-ups
`timescale 1ns/1ns

module pin_board (
    input  wire logic [5:0] oe,
    input  wire logic [5:0] out,
    input  wire logic [5:0] drv,
    input  wire logic [5:0] drv_en,
    output logic      [5:0] level
);
    // ================================================================
    // pin level
    // a released pin takes its external driver when enabled, else its pull-up, instead of keeping the last driven value
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (oe[i]) begin
                level[i] = out[i];
            end else if (drv_en[i]) begin
                level[i] = drv[i];
            end else begin
                level[i] = 1'b1;
            end
        end
    end
endmodule

//--- dv/tb_six_bit_bidir_port.sv
// self-checking bench of the six-bit port over its register bus
`timescale 1ns/1ns
`include "gpio_map.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end

module tb_six_bit_bidir_port;
    logic        sys_clk;
    logic        rstn;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [5:0]  pin_level;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe;
    logic [5:0]  drv;
    logic [5:0]  drv_en;
    int          miscompares;
    int          n_tests;

    six_bit_bidir_port i_six_bit_bidir_port (
        .SYS_CLK    (sys_clk),
        .RSTN       (rstn),
        .ADDRESS    (address),
        .READ       (read),
        .WRITE      (write),
        .WRITEDATA  (writedata),
        .BYTEENABLE (byteenable),
        .READDATA   (readdata),
        .WAITREQUEST(waitrequest),
        .PIN_IN     (pin_level),
        .PIN_OUT    (pin_out),
        .PIN_OE     (pin_oe)
    );

    pin_board i_pin_board (
        .oe    (pin_oe),
        .out   (pin_out),
        .drv   (drv),
        .drv_en(drv_en),
        .level (pin_level)
    );

    always #50 sys_clk = ~sys_clk;

    // ================================================================
    // closing report
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ================================================================
    // bus access: request held until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                            input logic [3:0] be, output logic [31:0] q);
        int n;
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        read       <= ~wr;
        write      <= wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        // the verdict ends the run, so nothing may follow it on this path
        if (waitrequest !== 1'b0) begin
            miscompares++;
            $display("[ERR] %0t bus access never answered", $time);
            complete_run();
        end else begin
            q = readdata;
            read  <= 1'b0;
            write <= 1'b0;
            // one idle edge so the next request never reassigns in the same step
            @(posedge sys_clk);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'h1);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, be, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, 4'hF, q);
        `CHK(q, exp)
    endtask

    // pins follow the registers one edge late and are sampled one edge later
    task automatic settle;
        repeat (3) @(posedge sys_clk);
    endtask

    // ================================================================
    // main sequence
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
        drv = 6'h2A;
        drv_en = 6'h3F;
        miscompares = 0;
        n_tests = 0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        `CHK(pin_oe, 6'h00)
        rd_chk(`OFS_DIRECTION, 32'h3F);
        rd_chk(`OFS_ANALOG_SEL, 32'h3F);
        rd_chk(`OFS_PORT_CFG, 32'h00);
        rd_chk(`OFS_PIN_VALUE, 32'h00);
        wr(`OFS_ANALOG_SEL, 32'h00);
        rd_chk(`OFS_PIN_VALUE, 32'h2A);
        wr(`OFS_DIRECTION, 32'hFF);
        rd_chk(`OFS_DIRECTION, 32'h3F);
        wr(`OFS_PIN_VALUE, 32'hD5);
        wr(`OFS_DIRECTION, 32'h00);
        settle();
        `CHK(pin_oe, 6'h37)
        `CHK(pin_out & 6'h37, 6'h15)
        rd_chk(`OFS_DIRECTION, 32'h08);
        rd_chk(`OFS_PIN_VALUE, 32'h1D);
        // pin 0 released, board drives it low, then a write without data lane
        wr(`OFS_DIRECTION, 32'h01);
        settle();
        wr(`OFS_PIN_VALUE, 32'h00, 4'h0);
        wr(`OFS_DIRECTION, 32'h00);
        settle();
        `CHK(pin_out & 6'h37, 6'h14)
        wr(`OFS_PORT_CFG, 32'h01);
        rd_chk(`OFS_PIN_VALUE, 32'h14);
        wr(`OFS_PORT_CFG, 32'h00);
        rd_chk(`OFS_PIN_VALUE, 32'h1C);
        for (int m = 1; m < 4; m++) begin
            wr(`OFS_PORT_CFG, 32'(m) << 1);
            settle();
            rd_chk(`OFS_DIRECTION, 32'h38);
            `CHK(pin_oe, 6'h07)
        end
        wr(`OFS_PORT_CFG, {29'h0, gpio_pkg::OSC_OTHER, 1'b0});
        rd_chk(`OFS_DIRECTION, 32'h08);
        wr(`OFS_PIN_VALUE, 32'h15);
        wr(`OFS_ANALOG_SEL, 32'h05);
        settle();
        rd_chk(`OFS_PIN_VALUE, 32'h18);
        `CHK(pin_oe, 6'h37)
        `CHK(pin_out & 6'h37, 6'h15)
        wr(`OFS_DIRECTION, 32'h05);
        settle();
        `CHK(pin_oe, 6'h32)
        wr(`OFS_DIRECTION, 32'h00, 4'h0);
        rd_chk(`OFS_DIRECTION, 32'h0D);
        // second reset in mid-run
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd_chk(`OFS_DIRECTION, 32'h3F);
        `CHK(pin_oe, 6'h00)
        // all pins released and undriven: every level comes from the pull-ups
        drv_en <= 6'h00;
        wr(`OFS_ANALOG_SEL, 32'h00);
        settle();
        rd_chk(`OFS_PIN_VALUE, 32'h3F);
        complete_run();
    end
endmodule

//--- rtl/gpio_map.svh
// register map, field positions, reset values and widths of the six-bit port
//
// Summary of operation
// - six pins, five bidirectional and pin three input only, each with its own output latch and direction bit
// - direction bit 1 turns the pin driver off, pin acts as input
// - direction bit 0 drives the latched output value onto the pin
// - pin three is input only, never driven, direction bit reads 1
// - pin register reads sampled pin levels; writes go to the output latch
// - a pin register write without byte lane 0 stores the pin read into the whole latch
// - with external reset pin selected, pin three reads 0
// - direction keeps controlling the driver on analog-configured pins
// - analog-configured pins read 0 on digital reads
// - direction bits 5 and 4 read 1 in any crystal oscillator mode
// - bits 7 and 6 of pin and direction registers ignore writes, read 0
// - analog select forces digital reads to 0, output function unaffected
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// ====================================================================
// bus geometry
`define BUS_ADDR_W      4
`define BUS_DATA_W      32
`define BUS_BE_W        4
`define BE_LANE0        0

// ====================================================================
// byte offsets of the words
`define OFS_PIN_VALUE   4'h0
`define OFS_DIRECTION   4'h4
`define OFS_PORT_CFG    4'h8
`define OFS_ANALOG_SEL  4'hC

// ====================================================================
// pin positions
`define PIN_COUNT       6
`define PIN_TOP         5
`define PIN_INPUT_ONLY  3
`define PIN_XTAL_HI     5
`define PIN_XTAL_LO     4

// ====================================================================
// configuration word fields
`define CFG_EXT_RST_BIT 0
`define CFG_OSC_LO      1
`define CFG_OSC_HI      2

// ====================================================================
// reset values
`define RST_LATCH       6'h00
`define RST_DIR         6'h3F
`define RST_ANALOG      6'h3F
`define RST_RDATA       32'h0000_0000

`endif

//--- rtl/gpio_pkg.sv
// types shared by the six-bit port
package gpio_pkg;

    // ================================================================
    // oscillator mode as seen by the port
    typedef enum logic [1:0] {
        OSC_OTHER                = 2'h0,
        CRYSTAL_MODE_LOW_POWER   = 2'h1,
        CRYSTAL_MODE_MEDIUM      = 2'h2,
        CRYSTAL_MODE_HIGH_SPEED  = 2'h3
    } osc_mode_e;

    // ================================================================
    // port configuration carried as one word
    typedef struct packed {
        osc_mode_e osc;
        logic      external_reset_pin_cfg;
    } port_cfg_s;

    // ================================================================
    // bus answer sequencer, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_e;

endpackage

//--- rtl/six_bit_bidir_port.sv
// six-bit bidirectional port with Avalon-MM register access
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "gpio_map.svh"

module six_bit_bidir_port #(
    parameter int PINS = `PIN_COUNT
) (
    input  wire logic                      SYS_CLK,
    input  wire logic                      RSTN,
    input  wire logic [`BUS_ADDR_W-1:0]    ADDRESS,
    input  wire logic                      READ,
    input  wire logic                      WRITE,
    input  wire logic [`BUS_DATA_W-1:0]    WRITEDATA,
    input  wire logic [`BUS_BE_W-1:0]      BYTEENABLE,
    output logic      [`BUS_DATA_W-1:0]    READDATA,
    output logic                           WAITREQUEST,
    input  wire logic [PINS-1:0]           PIN_IN,
    output logic      [PINS-1:0]           PIN_OUT,
    output logic      [PINS-1:0]           PIN_OE
);

    // ================================================================
    // state
    gpio_pkg::bus_state_e  bus_state_reg;
    gpio_pkg::port_cfg_s   cfg_reg;
    logic [PINS-1:0]       latch_reg;
    logic [PINS-1:0]       dir_reg;
    logic [PINS-1:0]       analog_sel_reg;
    logic [PINS-1:0]       pin_sample_reg;
    logic [PINS-1:0]       pin_out_reg;
    logic [PINS-1:0]       pin_oe_reg;
    logic [`BUS_DATA_W-1:0] rdata_reg;
    logic                  wait_reg;

    // ================================================================
    // decoded terms
    logic                  req;
    logic                  xfer;
    logic                  wr_xfer;
    logic                  lane0;
    logic [PINS-1:0]       pin_read;
    logic [PINS-1:0]       dir_read;
    logic [PINS-1:0]       eff_dir;
    logic [PINS-1:0]       latch_next;
    logic [`BUS_DATA_W-1:0] rdata_next;

    // ================================================================
    // decoding used by pin driver and direction read-back
    function automatic logic is_crystal(input gpio_pkg::osc_mode_e m);
        is_crystal = (m == gpio_pkg::CRYSTAL_MODE_LOW_POWER)
                  || (m == gpio_pkg::CRYSTAL_MODE_MEDIUM)
                  || (m == gpio_pkg::CRYSTAL_MODE_HIGH_SPEED);
    endfunction

    function automatic logic hit(input logic [`BUS_ADDR_W-1:0] a,
                                 input logic [`BUS_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // ================================================================
    // bus handshake terms
    assign req     = READ || WRITE;
    assign xfer    = req && !wait_reg;
    assign wr_xfer = WRITE && !wait_reg;
    assign lane0   = BYTEENABLE[`BE_LANE0];

    // ================================================================
    // digital read of the pins
    always_comb begin
        pin_read = pin_sample_reg;
        pin_read = pin_read & ~analog_sel_reg;
        if (cfg_reg.external_reset_pin_cfg) begin
            pin_read[`PIN_INPUT_ONLY] = 1'b0;
        end
    end

    // ================================================================
    // effective direction, also what software reads back
    always_comb begin
        eff_dir = dir_reg;
        eff_dir[`PIN_INPUT_ONLY] = 1'b1;
        if (is_crystal(cfg_reg.osc)) begin
            eff_dir[`PIN_XTAL_HI] = 1'b1;
            eff_dir[`PIN_XTAL_LO] = 1'b1;
        end
        dir_read = eff_dir;
    end

    // ================================================================
    // read multiplexer; upper bits and unmapped words read zero
    always_comb begin
        rdata_next = `RST_RDATA;
        if (hit(ADDRESS, `OFS_PIN_VALUE)) begin
            rdata_next[PINS-1:0] = pin_read;
        end else if (hit(ADDRESS, `OFS_DIRECTION)) begin
            rdata_next[PINS-1:0] = dir_read;
        end else if (hit(ADDRESS, `OFS_PORT_CFG)) begin
            rdata_next[`CFG_EXT_RST_BIT] = cfg_reg.external_reset_pin_cfg;
            rdata_next[`CFG_OSC_HI:`CFG_OSC_LO] = cfg_reg.osc;
        end else if (hit(ADDRESS, `OFS_ANALOG_SEL)) begin
            rdata_next[PINS-1:0] = analog_sel_reg;
        end
    end

    // ================================================================
    // bus sequencer: one wait cycle, then the answer edge
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            bus_state_reg <= gpio_pkg::BUS_IDLE;
        end else begin
            unique case (bus_state_reg)
                gpio_pkg::BUS_IDLE: begin
                    if (req) begin
                        bus_state_reg <= gpio_pkg::BUS_ANSWER;
                    end
                end
                gpio_pkg::BUS_ANSWER: begin
                    bus_state_reg <= gpio_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= gpio_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !(bus_state_reg == gpio_pkg::BUS_IDLE && req);
        end
    end

    // read data is caught one edge ahead and stands at the answer edge
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_reg <= `RST_RDATA;
        end else if (bus_state_reg == gpio_pkg::BUS_IDLE && READ) begin
            rdata_reg <= rdata_next;
        end
    end

    // ================================================================
    // pin sampling; pins are taken as synchronous to the clock
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_sample_reg <= '0;
        end else begin
            pin_sample_reg <= PIN_IN;
        end
    end

    // ================================================================
    // output latch: a write without lane 0 still stores the pin read,
    // so analog pins and pins pulled elsewhere land in the latch as read
    always_comb begin
        latch_next = pin_read;
        if (lane0) begin
            latch_next = WRITEDATA[PINS-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            latch_reg <= `RST_LATCH;
        end else if (wr_xfer && hit(ADDRESS, `OFS_PIN_VALUE)) begin
            latch_reg <= latch_next;
        end
    end

    // ================================================================
    // direction register; pin three keeps a constant 1
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            dir_reg <= `RST_DIR;
        end else if (wr_xfer && lane0 && hit(ADDRESS, `OFS_DIRECTION)) begin
            dir_reg <= WRITEDATA[PINS-1:0];
            dir_reg[`PIN_INPUT_ONLY] <= 1'b1;
        end
    end

    // ================================================================
    // configuration and analog select
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_reg.external_reset_pin_cfg <= 1'b0;
            cfg_reg.osc                    <= gpio_pkg::OSC_OTHER;
        end else if (wr_xfer && lane0 && hit(ADDRESS, `OFS_PORT_CFG)) begin
            cfg_reg.external_reset_pin_cfg <= WRITEDATA[`CFG_EXT_RST_BIT];
            cfg_reg.osc <= gpio_pkg::osc_mode_e'(WRITEDATA[`CFG_OSC_HI:`CFG_OSC_LO]);
        end
    end

    // analog select changes reads only; drivers ignore it
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            analog_sel_reg <= `RST_ANALOG;
        end else if (wr_xfer && lane0 && hit(ADDRESS, `OFS_ANALOG_SEL)) begin
            analog_sel_reg <= WRITEDATA[PINS-1:0];
        end
    end

    // ================================================================
    // pin drivers, one flop pair per pin
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_ff @(posedge SYS_CLK or negedge RSTN) begin
            if (!RSTN) begin
                pin_out_reg[i] <= 1'b0;
                pin_oe_reg[i]  <= 1'b0;
            end else begin
                pin_out_reg[i] <= latch_reg[i];
                pin_oe_reg[i]  <= !eff_dir[i];
            end
        end
    end

    // ================================================================
    // outputs
    assign READDATA    = rdata_reg;
    assign WAITREQUEST = wait_reg;
    assign PIN_OUT     = pin_out_reg;
    assign PIN_OE      = pin_oe_reg;

    // ================================================================
    // assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    AST_OE_FOLLOWS_DIR: assert property (
        ##1 (PIN_OE == ~$past(eff_dir)))
        else $error("driver enable does not follow direction");

    AST_OUT_FOLLOWS_LATCH: assert property (
        ##1 (PIN_OUT == $past(latch_reg)))
        else $error("pin output does not follow latch");

    AST_PIN3_NEVER_DRIVEN: assert property (
        !PIN_OE[`PIN_INPUT_ONLY])
        else $error("input-only pin driven");

    AST_DIR3_READS_ONE: assert property (
        (READ && xfer && hit(ADDRESS, `OFS_DIRECTION)) |-> READDATA[`PIN_INPUT_ONLY])
        else $error("pin three direction read as 0");

    AST_PIN_READ_SAMPLED: assert property (
        (READ && xfer && hit(ADDRESS, `OFS_PIN_VALUE))
        |-> (READDATA[PINS-1:0] == $past(pin_read)))
        else $error("pin read does not return sampled levels");

    AST_RMW_WRITE: assert property (
        (wr_xfer && !lane0 && hit(ADDRESS, `OFS_PIN_VALUE))
        |=> (latch_reg == $past(pin_read)))
        else $error("partial pin write did not store pin read");

    AST_EXT_RESET_PIN3: assert property (
        (READ && xfer && hit(ADDRESS, `OFS_PIN_VALUE) && cfg_reg.external_reset_pin_cfg)
        |-> !READDATA[`PIN_INPUT_ONLY])
        else $error("pin three not 0 with external reset selected");

    AST_ANALOG_READS_ZERO: assert property (
        (READ && xfer && hit(ADDRESS, `OFS_PIN_VALUE))
        |-> ((READDATA[PINS-1:0] & analog_sel_reg) == '0))
        else $error("analog pin read as 1");

    AST_CRYSTAL_DIR: assert property (
        (READ && xfer && hit(ADDRESS, `OFS_DIRECTION) && is_crystal(cfg_reg.osc))
        |-> (READDATA[`PIN_XTAL_HI:`PIN_XTAL_LO] == 2'h3))
        else $error("oscillator pins direction not 1 in crystal mode");

    AST_UPPER_ZERO: assert property (
        (READ && xfer) |-> (READDATA[`BUS_DATA_W-1:PINS] == '0))
        else $error("unimplemented bits read nonzero");

    AST_ANSWER_BOUND: assert property (
        (req && wait_reg && bus_state_reg == gpio_pkg::BUS_IDLE) |=> !WAITREQUEST)
        else $error("answer not given one cycle after request");

    COV_PIN_WRITE: cover property (wr_xfer && lane0 && hit(ADDRESS, `OFS_PIN_VALUE));
    COV_RMW_WRITE: cover property (wr_xfer && !lane0 && hit(ADDRESS, `OFS_PIN_VALUE));
    COV_PIN_DRIVEN: cover property (PIN_OE != '0);
    COV_CRYSTAL_READ: cover property (
        READ && xfer && hit(ADDRESS, `OFS_DIRECTION) && is_crystal(cfg_reg.osc));

endmodule
